// ### hdl/fpec_pkg.sv
// Purpose: Shared types and constants for the flash program and erase host controller.
// Assumes: 200 MHz clock, word-mode (x16) flash bus, ready/busy pin high when ready.
// Notes:   Times are in ns; cycle counts derive from them at the clock period.
`default_nettype none
package fpec_pkg;
    // ****************************************************************
    // Widths and bus command codes
    // ****************************************************************
    localparam int AW = 26;
    localparam int DW = 16;
    localparam int SECT_LSB = 16;           // 64 Kword sector.
    localparam int LINE_LSB = 8;            // 512-byte line is 256 words.
    localparam logic [AW-1:0] UNLOCK1_ADDR = 26'h0000555;
    localparam logic [AW-1:0] UNLOCK2_ADDR = 26'h00002AA;
    localparam logic [DW-1:0] UNLOCK1_DATA = 16'h00AA;
    localparam logic [DW-1:0] UNLOCK2_DATA = 16'h0055;
    localparam logic [DW-1:0] PROG_SETUP   = 16'h00A0;
    localparam logic [DW-1:0] ERASE_SETUP  = 16'h0080;
    localparam logic [DW-1:0] SECT_ERASE   = 16'h0030;
    localparam logic [DW-1:0] ERASE_SUSP   = 16'h00B0;
    localparam logic [DW-1:0] ERASE_RES    = 16'h0030;
    localparam logic [DW-1:0] PROG_SUSP    = 16'h0051;
    localparam logic [DW-1:0] PROG_RES     = 16'h0050;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int CLK_NS      = 5;
    localparam int T_WP_NS     = 35;        // Least write pulse width.
    localparam int T_WPH_NS    = 20;        // Least write pulse high time.
    localparam int T_ACC_NS    = 110;       // Least wait for read data.
    localparam int T_RP_NS     = 200;       // Least reset pulse width.
    localparam int T_BUSY_NS   = 80;        // Least wait before ready/busy is valid.
    localparam int T_RPH_NS    = 35000;     // reset_recovery_time.
    localparam int T_PRS_NS    = 40000;     // program_resume_interval.
    localparam int T_ERS_NS    = 40000;     // erase_resume_interval.
    localparam int WP_CYC      = (T_WP_NS + CLK_NS - 1) / CLK_NS;
    localparam int WPH_CYC     = (T_WPH_NS + CLK_NS - 1) / CLK_NS;
    localparam int ACC_CYC     = (T_ACC_NS + CLK_NS - 1) / CLK_NS;
    localparam int RP_CYC      = (T_RP_NS + CLK_NS - 1) / CLK_NS;
    localparam int BUSY_CYC    = (T_BUSY_NS + CLK_NS - 1) / CLK_NS;
    localparam int RPH_CYC_DEF = (T_RPH_NS + CLK_NS - 1) / CLK_NS;
    localparam int PRS_CYC_DEF = (T_PRS_NS + CLK_NS - 1) / CLK_NS;
    localparam int ERS_CYC_DEF = (T_ERS_NS + CLK_NS - 1) / CLK_NS;

    // ****************************************************************
    // Types
    // ****************************************************************
    typedef enum logic [2:0] {
        OP_READ, OP_PROG, OP_ERASE, OP_SUSPEND, OP_RESUME, OP_RESET
    } fpec_op_t;

    typedef struct packed {
        fpec_op_t         op;
        logic             no_unlock;        // Overlay form without unlock writes.
        logic [AW-1:0]    addr;
        logic [DW-1:0]    data;
    } fpec_cmd_t;

    typedef struct packed {
        logic [AW-1:0]    addr;
        logic [DW-1:0]    dq_o;
        logic             dq_oe;
        logic             ce_n;
        logic             oe_n;
        logic             we_n;
        logic             reset_n;
    } fpec_pins_t;

    typedef struct packed {
        logic [AW-1:0]    addr;
        logic [DW-1:0]    data;
    } fpec_cyc_t;

    typedef struct packed {
        logic             run_prog;
        logic             run_erase;
        logic             susp_prog;
        logic             susp_erase;
        logic             flash_busy;
    } fpec_stat_t;

    localparam fpec_pins_t PINS_RST = '{addr: '0, dq_o: '0, dq_oe: 1'b0, ce_n: 1'b1,
                                        oe_n: 1'b1, we_n: 1'b1, reset_n: 1'b1};
endpackage
`default_nettype wire

// ### hdl/fpec_host.sv
// Purpose: Host controller driving a parallel NOR flash through its command write cycles.
// Assumes: One command at a time on cmd_*; ready/busy input is asynchronous to clk.
// Notes:   Commands the flash would ignore in its present state are refused here instead.
`default_nettype none
module fpec_host
    import fpec_pkg::*;
#(
    parameter int RPH_CYC = RPH_CYC_DEF,
    parameter int PRS_CYC = PRS_CYC_DEF,
    parameter int ERS_CYC = ERS_CYC_DEF
) (
    input  wire logic            clk,
    input  wire logic            resetn,
    input  wire logic            cmd_valid,
    output logic                 cmd_ready,
    input  wire fpec_cmd_t       cmd_i,
    input  wire logic            ext_temp,
    output logic                 rsp_valid,
    output logic [DW-1:0]        rsp_data,
    output logic                 refused,
    output logic                 aborted,
    output logic                 done,
    output fpec_stat_t           stat_o,
    output fpec_pins_t           pins_o,
    input  wire logic [DW-1:0]   flash_dq_i,
    input  wire logic            flash_ryby_i
);
    typedef enum logic [2:0] {ST_IDLE, ST_WLO, ST_WHI, ST_RD, ST_RLO, ST_RREC} fpec_st_t;

    fpec_st_t       st_q, st_d;
    fpec_cmd_t      cmd_q, cmd_d;
    fpec_cyc_t      cyc_q, cyc_d;
    fpec_pins_t     pins_d;
    logic [15:0]    tmr_q, tmr_d;
    logic [15:0]    res_q;
    logic [7:0]     guard_q;
    logic [2:0]     step_q, step_d;
    logic [2:0]     rb_q;
    logic           rb_ready_q;
    logic           run_prog_q, run_erase_q, susp_prog_q, susp_erase_q;
    logic [AW-1:SECT_LSB] sect_q;
    logic [AW-1:LINE_LSB] line_q;

    // ****************************************************************
    // Command sequences
    // ****************************************************************
    // Number of bus writes for a command; suspend and resume are single writes.
    function automatic logic [2:0] seq_len(input fpec_cmd_t c);
        case (c.op)
            OP_PROG:  seq_len = c.no_unlock ? 3'd2 : 3'd4;
            OP_ERASE: seq_len = 3'd6;
            default:  seq_len = 3'd1;
        endcase
    endfunction

    // Address and data of write number idx; sel picks the program or erase code of suspend and resume.
    function automatic fpec_cyc_t cyc_at(input fpec_cmd_t c, input logic sel,
                                         input logic [2:0] idx);
        logic [2:0] k;
        k = (c.op != OP_PROG) ? idx : (idx == seq_len(c) - 3'd1) ? 3'd5
            : c.no_unlock ? 3'd2 : idx;
        cyc_at = '{addr: c.addr, data: c.data};
        case (c.op)
            OP_PROG, OP_ERASE: begin
                case (k)
                    3'd0, 3'd3: cyc_at = '{addr: UNLOCK1_ADDR, data: UNLOCK1_DATA};
                    3'd1, 3'd4: cyc_at = '{addr: UNLOCK2_ADDR, data: UNLOCK2_DATA};
                    3'd2: cyc_at = '{addr: (c.op == OP_PROG && c.no_unlock) ? c.addr
                                            : UNLOCK1_ADDR,
                                     data: (c.op == OP_PROG) ? PROG_SETUP : ERASE_SETUP};
                    default: cyc_at = '{addr: c.addr,
                                        data: (c.op == OP_PROG) ? c.data : SECT_ERASE};
                endcase
            end
            OP_SUSPEND: cyc_at.data = sel ? PROG_SUSP : ERASE_SUSP;
            OP_RESUME:  cyc_at.data = sel ? PROG_RES : ERASE_RES;
            default: ;
        endcase
    endfunction

    // ****************************************************************
    // Legality of a new command against the flash state
    // ****************************************************************
    // Refusing here keeps the flash from silently dropping a command we believe it took.
    wire run_any  = run_prog_q | run_erase_q;
    wire sect_hit = cmd_i.addr[AW-1:SECT_LSB] == sect_q;
    wire line_hit = cmd_i.addr[AW-1:LINE_LSB] == line_q;
    wire ok_read  = !(susp_prog_q && line_hit);
    wire ok_prog  = !run_any && !susp_prog_q && !(susp_erase_q && sect_hit)
                    && !(ext_temp && !cmd_i.no_unlock);
    wire ok_erase = !run_any && !susp_prog_q && !susp_erase_q;
    wire ok_susp  = run_any && res_q == 16'h0000;
    wire ok_res   = !run_any && (susp_prog_q || susp_erase_q);
    wire cmd_ok   = (cmd_i.op == OP_READ)    ? ok_read :
                    (cmd_i.op == OP_PROG)    ? ok_prog :
                    (cmd_i.op == OP_ERASE)   ? ok_erase :
                    (cmd_i.op == OP_SUSPEND) ? ok_susp :
                    (cmd_i.op == OP_RESUME)  ? ok_res : 1'b1;
    wire run_done = run_any && guard_q == 8'h00 && rb_ready_q && st_q == ST_IDLE;
    wire tmr_zero = tmr_q == 16'h0000;
    wire last     = step_q == seq_len(cmd_q) - 3'd1;
    wire wr_fin   = st_q == ST_WHI && tmr_zero && last;
    wire sel_new  = (cmd_i.op == OP_SUSPEND) ? run_prog_q : susp_prog_q;
    wire accept   = cmd_valid && cmd_ready;

    assign cmd_ready = st_q == ST_IDLE && guard_q == 8'h00 && !run_done;

    // ****************************************************************
    // Bus cycle sequencer
    // ****************************************************************
    // One state per phase of a write, read or reset pulse; tmr counts the phase length.
    always_comb begin
        st_d   = st_q;
        cmd_d  = cmd_q;
        cyc_d  = cyc_q;
        step_d = step_q;
        tmr_d  = tmr_zero ? tmr_q : tmr_q - 16'h0001;
        case (st_q)
            ST_IDLE: begin
                if (accept && cmd_ok) begin
                    cmd_d = cmd_i;
                    cyc_d = '{addr: cmd_i.addr, data: cmd_i.data};
                    case (cmd_i.op)
                        OP_READ: begin
                            st_d  = ST_RD;
                            tmr_d = 16'(ACC_CYC);
                        end
                        OP_RESET: begin
                            st_d  = ST_RLO;
                            tmr_d = 16'(RP_CYC);
                        end
                        default: begin
                            st_d   = ST_WLO;
                            step_d = 3'd0;
                            cyc_d  = cyc_at(cmd_i, sel_new, 3'd0);
                            tmr_d  = 16'(WP_CYC);
                        end
                    endcase
                end
            end
            ST_WLO: begin
                if (tmr_zero) begin
                    st_d  = ST_WHI;
                    tmr_d = 16'(WPH_CYC);
                end
            end
            ST_WHI: begin
                if (tmr_zero && last) begin
                    st_d = ST_IDLE;
                end else if (tmr_zero) begin
                    st_d   = ST_WLO;
                    step_d = step_q + 3'd1;
                    cyc_d  = cyc_at(cmd_q, 1'b0, step_q + 3'd1);
                    tmr_d  = 16'(WP_CYC);
                end
            end
            ST_RD: begin
                if (tmr_zero) begin
                    st_d = ST_IDLE;
                end
            end
            ST_RLO: begin
                if (tmr_zero) begin
                    st_d  = ST_RREC;
                    tmr_d = 16'(RPH_CYC);
                end
            end
            ST_RREC: begin
                if (tmr_zero) begin
                    st_d = ST_IDLE;
                end
            end
            default: st_d = ST_IDLE;
        endcase
    end

    // Pins are decoded from the next state so every strobe leaves a flip-flop clean.
    assign pins_d = '{addr: cyc_d.addr, dq_o: cyc_d.data,
                      dq_oe: st_d == ST_WLO || st_d == ST_WHI,
                      ce_n: !(st_d == ST_WLO || st_d == ST_WHI || st_d == ST_RD),
                      oe_n: st_d != ST_RD, we_n: st_d != ST_WLO, reset_n: st_d != ST_RLO};

    always_ff @(posedge clk) begin
        if (!resetn) begin
            st_q   <= ST_IDLE;
            cmd_q  <= '0;
            cyc_q  <= '0;
            step_q <= 3'd0;
            tmr_q  <= 16'h0000;
            pins_o <= PINS_RST;
        end else begin
            st_q   <= st_d;
            cmd_q  <= cmd_d;
            cyc_q  <= cyc_d;
            step_q <= step_d;
            tmr_q  <= tmr_d;
            pins_o <= pins_d;
        end
    end

    // ****************************************************************
    // Ready/busy synchroniser
    // ****************************************************************
    // A level counts only once the second and third stages agree, which masks a slow edge.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            rb_q       <= 3'b111;
            rb_ready_q <= 1'b1;
        end else begin
            rb_q <= {rb_q[1:0], flash_ryby_i};
            if (rb_q[1] == rb_q[2]) begin
                rb_ready_q <= rb_q[2];
            end
        end
    end

    // ****************************************************************
    // Operation tracking
    // ****************************************************************
    // The guard hides the window after a write in which ready/busy has not yet fallen.
    always_ff @(posedge clk) begin
        if (!resetn || st_q == ST_RLO) begin
            {run_prog_q, run_erase_q, susp_prog_q, susp_erase_q} <= 4'b0000;
            sect_q  <= '0;
            line_q  <= '0;
            res_q   <= 16'h0000;
            guard_q <= 8'h00;
        end else begin
            res_q   <= (res_q == 16'h0000) ? res_q : res_q - 16'h0001;
            guard_q <= (guard_q == 8'h00) ? guard_q : guard_q - 8'h01;
            if (wr_fin) begin
                guard_q <= 8'(BUSY_CYC);
                case (cmd_q.op)
                    OP_PROG: begin
                        run_prog_q <= 1'b1;
                        line_q     <= cmd_q.addr[AW-1:LINE_LSB];
                    end
                    OP_ERASE: begin
                        run_erase_q <= 1'b1;
                        sect_q      <= cmd_q.addr[AW-1:SECT_LSB];
                    end
                    OP_SUSPEND: begin
                        if (run_prog_q) begin
                            {run_prog_q, susp_prog_q} <= 2'b01;
                        end else begin
                            {run_erase_q, susp_erase_q} <= 2'b01;
                        end
                    end
                    OP_RESUME: begin
                        if (susp_prog_q) begin
                            {run_prog_q, susp_prog_q} <= 2'b10;
                            res_q <= 16'(PRS_CYC);
                        end else begin
                            {run_erase_q, susp_erase_q} <= 2'b10;
                            res_q <= 16'(ERS_CYC);
                        end
                    end
                    default: ;
                endcase
            end else if (run_done) begin
                // Erase suspend state survives a finished program.
                if (run_prog_q) begin
                    run_prog_q <= 1'b0;
                end else begin
                    run_erase_q <= 1'b0;
                end
            end
        end
    end

    // ****************************************************************
    // Answers and event pulses
    // ****************************************************************
    // Read data is sampled once the access time has run out, so it has settled.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            rsp_valid <= 1'b0;
            rsp_data  <= '0;
            refused   <= 1'b0;
            aborted   <= 1'b0;
            done      <= 1'b0;
        end else begin
            rsp_valid <= st_q == ST_RD && tmr_zero;
            rsp_data  <= (st_q == ST_RD && tmr_zero) ? flash_dq_i : rsp_data;
            refused   <= accept && !cmd_ok;
            aborted   <= accept && cmd_i.op == OP_RESET &&
                         (run_any || susp_prog_q || susp_erase_q);
            done      <= run_done;
        end
    end

    assign stat_o = '{run_prog: run_prog_q, run_erase: run_erase_q, susp_prog: susp_prog_q,
                      susp_erase: susp_erase_q, flash_busy: !rb_ready_q};
endmodule
`default_nettype wire

// ### dv/fpec_flash_model.sv
// Purpose: Behavioural flash device that answers the host controller's pins.
// Assumes: Word mode; a write is latched as we_n rises with ce_n low.
// Notes:   Array effects land when an operation starts; busy is timing only.
`default_nettype none
module fpec_flash_model
    import fpec_pkg::*;
#(
    parameter int OP_CYC  = 300,
    parameter int REC_CYC = 20
) (
    input  wire logic       clk,
    input  wire fpec_pins_t pins,
    output logic [DW-1:0]   dq,
    output logic            ryby
);
    timeunit 1ns;
    timeprecision 100ps;
    // ****************************************************************
    // Array, command decoder and busy timer
    // ****************************************************************
    logic [DW-1:0] mem [logic [AW-1:0]];
    int            step = 0, left = 0, held = 0, rec = 0;
    logic          hprog = 1'b0, er = 1'b0, we_q = 1'b1;

    // Decodes one latched write; a held operation survives so that the
    // device falls back to erase suspend after a nested program.
    task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
        if (left > 0) begin
            if (d == ERASE_SUSP || d == PROG_SUSP) begin
                held = left;
                left = 0;
                hprog = !er;
            end
        end else if (step == 0 && held > 0 && (d == ERASE_RES || d == PROG_RES)) begin
            left = held;
            held = 0;
        end else if (step == 0)
            step = (a == UNLOCK1_ADDR && d == UNLOCK1_DATA) ? 1 : (d == PROG_SETUP) ? 3 : 0;
        else if (step == 1)
            step = (a == UNLOCK2_ADDR && d == UNLOCK2_DATA) ? 2 : 0;
        else if (step == 2)
            step = (d == PROG_SETUP) ? 3 : (d == ERASE_SETUP) ? 4 : 0;
        else if (step == 4 || step == 5)
            step = (d == (step == 4 ? UNLOCK1_DATA : UNLOCK2_DATA)) ? step + 1 : 0;
        else if (step == 3) begin
            step = 0;
            if (!(held > 0 && hprog)) begin
                mem[a] = (mem.exists(a) ? mem[a] : '1) & d;
                left = OP_CYC;
                er = 1'b0;
            end
        end else begin
            step = 0;
            if (d == SECT_ERASE && held == 0) begin
                foreach (mem[k]) if (k[AW-1:SECT_LSB] == a[AW-1:SECT_LSB]) mem[k] = '1;
                left = OP_CYC;
                er = 1'b1;
            end
        end
    endtask

    // Released bus toggles so that a stale value can never be mistaken for data.
    always @(posedge clk) begin
        if (!pins.reset_n) begin
            step = 0;
            left = 0;
            held = 0;
            rec = REC_CYC;
        end else begin
            if (rec > 0) rec--;
            if (left > 0) left--;
            if (!we_q && pins.we_n && !pins.ce_n) wr(pins.addr, pins.dq_o);
        end
        we_q = pins.we_n;
        ryby <= (left == 0) && (rec == 0);
        dq <= (!pins.ce_n && !pins.oe_n) ?
              (mem.exists(pins.addr) ? mem[pins.addr] : '1) : ~dq;
    end
    initial dq = 16'h0000;
    initial ryby = 1'b1;
endmodule
`default_nettype wire

// ### dv/fpec_host_props.sv
// Purpose: Port-level assertions for the flash host controller.
// Assumes: One clock domain; sees only the top module's ports.
// Notes:   Write and read cycle counts follow the package timing at a 5 ns clock; the reset pin check asks for 8 low cycles.
`default_nettype none
module fpec_host_props
    import fpec_pkg::*;
(
    input wire logic       clk,
    input wire logic       resetn,
    input wire logic       cmd_valid,
    input wire logic       cmd_ready,
    input wire fpec_cmd_t  cmd_i,
    input wire logic       ext_temp,
    input wire logic       rsp_valid,
    input wire logic       refused,
    input wire logic       aborted,
    input wire logic       done,
    input wire fpec_stat_t stat_o,
    input wire fpec_pins_t pins_o
);
    timeunit 1ns;
    timeprecision 100ps;
    // ****************************************************************
    // Command outcomes and pin sequences
    // ****************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    wire take = cmd_valid && cmd_ready;
    wire busy = stat_o.run_prog || stat_o.run_erase;
    sequence s_prog; take && cmd_i.op == OP_PROG && !cmd_i.no_unlock; endsequence
    sequence s_unl1; !pins_o.we_n && pins_o.addr == UNLOCK1_ADDR && pins_o.dq_o == UNLOCK1_DATA; endsequence
    sequence s_unl2; !pins_o.we_n && pins_o.addr == UNLOCK2_ADDR && pins_o.dq_o == UNLOCK2_DATA; endsequence

    prog_start_a: assert property (s_prog |=> (refused or s_unl1))
        else $error("program did not open with the first unlock write");
    prog_unlock_a: assert property (s_prog ##1 s_unl1 |-> ##13 s_unl2)
        else $error("second unlock write out of place");
    refuse_quiet_a: assert property (refused |-> pins_o.we_n && pins_o.ce_n)
        else $error("refused command reached the pins");
    run_block_a: assert property (take && busy && cmd_i.op inside {OP_PROG, OP_ERASE, OP_RESUME} |=> refused)
        else $error("command accepted while an operation runs");
    susp_prog_a: assert property (take && stat_o.susp_prog && cmd_i.op inside {OP_PROG, OP_ERASE} |=> refused)
        else $error("program or erase accepted in program suspend");
    susp_erase_a: assert property (take && stat_o.susp_erase && cmd_i.op == OP_ERASE |=> refused)
        else $error("erase accepted in erase suspend");
    ext_temp_a: assert property (take && ext_temp && cmd_i.op == OP_PROG && !cmd_i.no_unlock |=> refused)
        else $error("word program accepted on extended part");
    done_idle_a: assert property (done |-> !busy && !stat_o.flash_busy)
        else $error("done while still busy");
    reset_pin_a: assert property (take && cmd_i.op == OP_RESET |=> !pins_o.reset_n [*8])
        else $error("reset pin pulse too short");
    abort_a: assert property (take && cmd_i.op == OP_RESET && (busy || stat_o.susp_prog || stat_o.susp_erase) |=> aborted)
        else $error("reset over an operation not flagged");
    read_ans_a: assert property (take && cmd_i.op == OP_READ ##1 !refused |-> ##23 rsp_valid)
        else $error("read answer late or missing");
endmodule
bind fpec_host fpec_host_props i_props (.clk(clk), .resetn(resetn), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_i(cmd_i), .ext_temp(ext_temp), .rsp_valid(rsp_valid),
    .refused(refused), .aborted(aborted), .done(done), .stat_o(stat_o), .pins_o(pins_o));
`default_nettype wire

// ### dv/fpec_host_tb_top.sv
// Purpose: Self-checking bench for the flash program and erase host controller.
// Assumes: Behavioural flash model with short busy and recovery counts.
// Notes:   Inputs change 1 ns after the rising edge.
`default_nettype none
module fpec_host_tb_top
    import fpec_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    // ****************************************************************
    // Clock, design and flash
    // ****************************************************************
    logic          clk, resetn, cmd_valid, cmd_ready, ext_temp, rsp_valid;
    logic          refused, aborted, done, ryby;
    fpec_cmd_t     cmd_i;
    fpec_stat_t    stat_o;
    fpec_pins_t    pins_o;
    logic [DW-1:0] rsp_data, dq;
    int            fails = 0, checks_done = 0;

    fpec_host #(.RPH_CYC(20), .PRS_CYC(20), .ERS_CYC(20)) i_dut (.clk(clk), .resetn(resetn),
        .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_i(cmd_i), .ext_temp(ext_temp),
        .rsp_valid(rsp_valid), .rsp_data(rsp_data), .refused(refused), .aborted(aborted),
        .done(done), .stat_o(stat_o), .pins_o(pins_o), .flash_dq_i(dq), .flash_ryby_i(ryby));
    fpec_flash_model i_flash (.clk(clk), .pins(pins_o), .dq(dq), .ryby(ryby));

    task automatic chk(input logic [DW-1:0] got, input logic [DW-1:0] exp);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Hands one command over; returns the aborted and refused pulses.
    task automatic issue(input fpec_op_t op, input logic nu, input logic [AW-1:0] a,
                         input logic [DW-1:0] d, output logic [1:0] ra);
        int n = 0;
        @(posedge clk) #1;
        cmd_i = '{op: op, no_unlock: nu, addr: a, data: d};
        cmd_valid = 1'b1;
        while (cmd_ready !== 1'b1 && ++n < 20000) @(posedge clk) #1;
        @(posedge clk);
        #1 cmd_valid = 1'b0;
        ra = {aborted, refused};
    endtask
    task automatic wait_done();
        int n = 0;
        while (done !== 1'b1 && ++n < 2000) @(posedge clk) #1;
        chk(16'(done), 16'h0001);
    endtask
    task automatic rd(input logic [AW-1:0] a, input logic [DW-1:0] exp);
        logic [1:0] ra;
        int n = 0;
        issue(OP_READ, 1'b0, a, 16'h0000, ra);
        while (rsp_valid !== 1'b1 && ++n < 100) @(posedge clk) #1;
        chk(16'(rsp_valid), 16'h0001);
        chk(rsp_data, exp);
    endtask
    // Holds a suspend off past the resume interval.
    task automatic gap();
        repeat (25) @(posedge clk);
        #1;
    endtask

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_prog();
        logic [1:0] ra;
        issue(OP_PROG, 1'b0, 26'h0000100, 16'hF0F0, ra);
        chk(16'(ra), 16'h0000);
        wait_done();
        issue(OP_PROG, 1'b0, 26'h0000100, 16'h3C3C, ra);
        wait_done();
        rd(26'h0000100, 16'h3030);
        $display("test program finished");
    endtask
    task automatic t_erase();
        logic [1:0] ra;
        issue(OP_PROG, 1'b0, 26'h0010004, 16'h0000, ra);
        wait_done();
        issue(OP_ERASE, 1'b0, 26'h0010000, 16'h0000, ra);
        issue(OP_ERASE, 1'b0, 26'h0010000, 16'h0000, ra);
        chk(16'(ra), 16'h0001);
        gap();
        issue(OP_SUSPEND, 1'b0, 26'h0010000, 16'h0000, ra);
        issue(OP_ERASE, 1'b0, 26'h0030000, 16'h0000, ra);
        chk(16'(ra), 16'h0001);
        issue(OP_PROG, 1'b0, 26'h0020005, 16'h00FF, ra);
        chk(16'(ra), 16'h0000);
        wait_done();
        chk(16'(stat_o.susp_erase), 16'h0001);
        issue(OP_RESUME, 1'b0, 26'h0010000, 16'h0000, ra);
        chk(16'(ra), 16'h0000);
        wait_done();
        rd(26'h0010004, 16'hFFFF);
        rd(26'h0020005, 16'h00FF);
        $display("test erase finished");
    endtask
    task automatic t_psusp();
        logic [1:0] ra;
        issue(OP_PROG, 1'b0, 26'h0000200, 16'h5555, ra);
        gap();
        issue(OP_SUSPEND, 1'b0, 26'h0000200, 16'h0000, ra);
        issue(OP_PROG, 1'b0, 26'h0000300, 16'h0000, ra);
        chk(16'(ra), 16'h0001);
        issue(OP_ERASE, 1'b0, 26'h0030000, 16'h0000, ra);
        chk(16'(ra), 16'h0001);
        issue(OP_READ, 1'b0, 26'h0000210, 16'h0000, ra);
        chk(16'(ra), 16'h0001);
        rd(26'h0000100, 16'h3030);
        issue(OP_RESUME, 1'b0, 26'h0000200, 16'h0000, ra);
        wait_done();
        rd(26'h0000200, 16'h5555);
        $display("test program suspend finished");
    endtask
    task automatic t_ext();
        logic [1:0] ra;
        ext_temp = 1'b1;
        issue(OP_PROG, 1'b0, 26'h0000400, 16'h0F0F, ra);
        chk(16'(ra), 16'h0001);
        issue(OP_PROG, 1'b1, 26'h0000400, 16'h0F0F, ra);
        chk(16'(ra), 16'h0000);
        wait_done();
        ext_temp = 1'b0;
        rd(26'h0000400, 16'h0F0F);
        $display("test overlay program finished");
    endtask
    task automatic t_reset();
        logic [1:0] ra;
        issue(OP_PROG, 1'b0, 26'h0000500, 16'h0000, ra);
        issue(OP_RESET, 1'b0, 26'h0000000, 16'h0000, ra);
        chk(16'(ra), 16'h0002);
        rd(26'h0000600, 16'hFFFF);
        $display("test reset finished");
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // Clock and main sequence; the watchdog allows about 40000 cycles.
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    initial begin
        resetn = 1'b0;
        cmd_valid = 1'b0;
        ext_temp = 1'b0;
        cmd_i = '0;
        repeat (12) @(posedge clk);
        #1 resetn = 1'b1;
        t_prog();
        t_erase();
        t_psusp();
        t_ext();
        t_reset();
        stop_test();
    end
    initial begin
        #200000;
        fails++;
        stop_test();
    end
endmodule
`default_nettype wire
